/* charge_bank_defines.svh */
`ifndef CHARGE_BANK_DEFINES_SVH
`define CHARGE_BANK_DEFINES_SVH

`define REV_ID_ADDR        8'h03
`define CHG_CUR_ADDR       8'h04
`define CHG_CUR_RESET      8'h89
`define CHG_RST_BIT        7
`define CHG_CODE_LSB       4
`define CHG_CODE_MSB       6
`define CHG_SPARE_BIT      3
`define TERM_CODE_LSB      0
`define TERM_CODE_MSB      2
`define UNMAPPED_READ      8'hff
// Sense voltages in units of 0.1 mV; one step equals the field LSB weight
`define CHG_OFFSET_DMV     16'h0176
`define CHG_STEP_DMV       16'h0044
`define TERM_OFFSET_DMV    16'h0022
`define TERM_STEP_DMV      16'h0022
// Arbitrary neutral revision value
`define REV_ID_VALUE       8'h52

`endif

/* charge_bank_pkg.sv */
package charge_bank_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic [2:0] chg_code;
        logic [2:0] term_code;
    } cur_cfg_s;

    typedef enum logic [1:0] {
        RST_IDLE  = 2'b00,
        RST_PULSE = 2'b01,
        RST_HOLD  = 2'b11
    } rst_state_e;

endpackage : charge_bank_pkg

/* sense_code_scale.sv */
`timescale 1ns/1ps
`include "charge_bank_defines.svh"

// Converts a 3-bit binary code to a sense voltage in 0.1 mV units, registered
module sense_code_scale #(
    parameter logic [15:0] OFFSET = 16'd0,
    parameter logic [15:0] STEP   = 16'd1
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [2:0]  code,
    output logic      [15:0] sense_dmv
);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sense_dmv <= 16'h0000;
        end else begin
            sense_dmv <= OFFSET + 16'(STEP * {13'h0000, code});
        end
    end

endmodule : sense_code_scale

/* charge_current_register_bank.sv */
// How it works
// - Writing one to bit 7 of register 04 resets the charger; zero does nothing.
// - Reading bit 7 of register 04 always returns one.
// - Bits 6:4 are charge code, weights 27.2/13.6/6.8 mV plus 37.4 mV offset.
// - Bits 2:0 are termination code, weights 13.6/6.8/3.4 mV plus 3.4 mV.
// - Register 04 resets to 89 hex.
// - One code step equals the field LSB weight over the sense resistance.
// - Register 03 is read-only and reports the revision in all eight bits.
// - The safety timer has no disable; it runs whenever charging is active.
`timescale 1ns/1ps
`include "charge_bank_defines.svh"

module charge_current_register_bank (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire charge_bank_pkg::reg_req_s req,
    output logic      [7:0]                rdata,
    output logic                           charger_reset,
    output charge_bank_pkg::cur_cfg_s      cur_cfg,
    output logic      [15:0]               charge_sense_code,
    output logic      [15:0]               term_sense_dmv,
    input  wire logic                      charging_active,
    output logic                           safety_timer_run
);

    logic [6:0]                  chg_reg_ff;
    logic                        rst_req_ff;
    charge_bank_pkg::rst_state_e rst_state_ff;
    charge_bank_pkg::rst_state_e nxt_rst_state;
    logic                        wr_chg;
    logic [2:0]                  chg_field;
    logic [2:0]                  term_field;

    assign wr_chg = req.wr && (req.addr == `CHG_CUR_ADDR);

    // Field views of the stored byte; bit 3 feeds neither of them
    assign chg_field  = chg_reg_ff[`CHG_CODE_MSB:`CHG_CODE_LSB];
    assign term_field = chg_reg_ff[`TERM_CODE_MSB:`TERM_CODE_LSB];

    // Register 03 has no write path at all
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            chg_reg_ff <= 7'(`CHG_CUR_RESET);
        end else if (wr_chg) begin
            chg_reg_ff <= req.wdata[6:0];
        end
    end

    // Reset bit is a write-one strobe; it is never stored
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rst_req_ff <= 1'b0;
        end else begin
            rst_req_ff <= wr_chg && req.wdata[`CHG_RST_BIT];
        end
    end

    // Requests are registered first, so the pulse never starts in the write cycle itself
    always_comb begin
        nxt_rst_state = rst_state_ff;
        case (rst_state_ff)
            charge_bank_pkg::RST_IDLE:  if (rst_req_ff) nxt_rst_state = charge_bank_pkg::RST_PULSE;
            charge_bank_pkg::RST_PULSE: nxt_rst_state = charge_bank_pkg::RST_HOLD;
            charge_bank_pkg::RST_HOLD:  nxt_rst_state = charge_bank_pkg::RST_IDLE;
            default:                    nxt_rst_state = charge_bank_pkg::RST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rst_state_ff <= charge_bank_pkg::RST_IDLE;
        end else begin
            rst_state_ff <= nxt_rst_state;
        end
    end

    // Two-cycle reset pulse so downstream charger logic sees it cleanly
    assign charger_reset = (rst_state_ff != charge_bank_pkg::RST_IDLE);

    // Reads are registered; a read and a write in one cycle return the old contents

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                `REV_ID_ADDR:  rdata <= `REV_ID_VALUE;
                `CHG_CUR_ADDR: rdata <= {1'b1, chg_reg_ff};
                default:       rdata <= `UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cur_cfg <= '0;
        end else begin
            cur_cfg.chg_code  <= chg_field;
            cur_cfg.term_code <= term_field;
        end
    end

    // Current per step is this LSB voltage over the external resistor
    sense_code_scale #(
        .OFFSET (`CHG_OFFSET_DMV),
        .STEP   (`CHG_STEP_DMV)
    ) u_chg_scale (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .code      (chg_field),
        .sense_dmv (charge_sense_code)
    );

    sense_code_scale #(
        .OFFSET (`TERM_OFFSET_DMV),
        .STEP   (`TERM_STEP_DMV)
    ) u_term_scale (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .code      (term_field),
        .sense_dmv (term_sense_dmv)
    );

    // No register bit can gate the timer
    assign safety_timer_run = charging_active;

    // A bit-7 write opens a new pulse unless one is pending or in its first cycle; one that lands there
    // merges into it, while one in the second pulse cycle starts a new pulse after one idle cycle
    sequence s_rst_request;
        wr_chg && req.wdata[`CHG_RST_BIT] && !rst_req_ff &&
            rst_state_ff == charge_bank_pkg::RST_IDLE;
    endsequence

    // Strobe registered first, then two high cycles, then idle again
    sequence s_rst_pulse;
        ##2 charger_reset [*2] ##1 !charger_reset;
    endsequence

    sequence s_pulse_tail;
        charger_reset [*2] ##1 !charger_reset;
    endsequence

    a_rst_bit_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        req.rd && req.addr == `CHG_CUR_ADDR |=> rdata[7])
        else $error("Reset bit read as zero");

    a_rst_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_rst_request |-> s_rst_pulse)
        else $error("Charger reset pulse missing");

    a_rst_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !rst_req_ff && rst_state_ff == charge_bank_pkg::RST_IDLE |=> !charger_reset)
        else $error("Charger reset without request");

    a_chg_sense: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $stable(chg_reg_ff) |=> charge_sense_code ==
            `CHG_OFFSET_DMV + `CHG_STEP_DMV * {13'h0000, $past(chg_field)})
        else $error("Charge sense value wrong");

    a_term_sense: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $stable(chg_reg_ff) |=> term_sense_dmv ==
            `TERM_OFFSET_DMV + `TERM_STEP_DMV * {13'h0000, $past(term_field)})
        else $error("Termination sense value wrong");

    a_reset_value: assert property (@(posedge ref_clk)
        !rst_n |=> chg_reg_ff == 7'(`CHG_CUR_RESET))
        else $error("Register 04 reset value wrong");

    a_rev_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        req.rd && req.addr == `REV_ID_ADDR |=> rdata == `REV_ID_VALUE)
        else $error("Revision read wrong");

    a_timer_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
        charging_active |-> safety_timer_run)
        else $error("Safety timer stopped while charging");

    a_spare_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_chg && req.wdata[`CHG_CODE_MSB:`CHG_CODE_LSB] == chg_field &&
            req.wdata[`TERM_CODE_MSB:`TERM_CODE_LSB] == term_field
        |=> ##1 $stable(cur_cfg))
        else $error("Spare bit changed current settings");

    // Bit 7 is a strobe and never lands in storage
    a_store_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_chg |=> {1'b0, chg_reg_ff} == ($past(req.wdata) & 8'h7f))
        else $error("Register 04 write not stored");

    // Both codes reach the charger one cycle after they are stored
    a_cfg_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
        rst_n |=> cur_cfg == {$past(chg_field), $past(term_field)})
        else $error("Current settings lag wrong");

    a_pulse_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(charger_reset) |-> s_pulse_tail)
        else $error("Charger reset pulse length wrong");

    a_rev_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        req.wr && req.addr == `REV_ID_ADDR |=> $stable(chg_reg_ff))
        else $error("Write to revision register disturbed register 04");

    a_unmapped_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        req.rd && req.addr != `REV_ID_ADDR && req.addr != `CHG_CUR_ADDR
        |=> rdata == `UNMAPPED_READ)
        else $error("Unmapped read not all ones");

    // Read data stands until the next read strobe
    a_rdata_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !req.rd |=> $stable(rdata))
        else $error("Read data changed without a read");

    a_reset_quiet: assert property (@(posedge ref_clk)
        !rst_n |=> !charger_reset)
        else $error("Charger reset active during reset");

endmodule : charge_current_register_bank

/* host_model.sv */
`timescale 1ns/1ps
module host_model (
    input  wire logic                 ref_clk,
    output charge_bank_pkg::reg_req_s req
);
    initial begin
        req = '0;
    end
    // One access per call; the strobes clear and addr and wdata turn to inverted junk on the taking edge itself,
    // so a call that follows at once never drives a field twice in one time step
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        req.wr    = w;
        req.rd    = ~w;
        req.addr  = a;
        req.wdata = d;
        @(posedge ref_clk);
        req.wr    <= 1'b0;
        req.rd    <= 1'b0;
        req.addr  <= ~a;
        req.wdata <= ~d;
        #1;
    endtask : access
endmodule : host_model

/* tb_charge_current_register_bank.sv */
`timescale 1ns/1ps
`include "charge_bank_defines.svh"
module tb_charge_current_register_bank;
    logic                      ref_clk = 1'b0;
    logic                      rst_n   = 1'b0;
    logic                      charging_active = 1'b0;
    charge_bank_pkg::reg_req_s req;
    charge_bank_pkg::cur_cfg_s cur_cfg;
    logic [7:0]                rdata;
    logic                      charger_reset;
    logic [15:0]               charge_sense_code;
    logic [15:0]               term_sense_dmv;
    logic                      safety_timer_run;
    int                        fail_count = 0;
    int                        n_checks   = 0;

    host_model host_model_i (.ref_clk(ref_clk), .req(req));
    charge_current_register_bank charge_current_register_bank_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
        .charger_reset(charger_reset), .cur_cfg(cur_cfg),
        .charge_sense_code(charge_sense_code), .term_sense_dmv(term_sense_dmv),
        .charging_active(charging_active), .safety_timer_run(safety_timer_run));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run

    task automatic read_exp(input logic [7:0] a, input logic [7:0] exp);
        host_model_i.access(1'b0, a, 8'h00);
        check("rdata", {8'h00, rdata}, {8'h00, exp});
    endtask : read_exp

    // Writes, then counts reset-pulse cycles; settled outputs are compared after
    task automatic write_cfg(input logic [7:0] d, input logic [15:0] pulses,
                             input logic [15:0] chg, input logic [15:0] term);
        logic [15:0] n;
        n = 16'h0;
        host_model_i.access(1'b1, `CHG_CUR_ADDR, d);
        repeat (6) begin
            @(posedge ref_clk);
            #1;
            if (charger_reset === 1'b1) n++;
        end
        check("charger_reset cycles", n, pulses);
        check("cur_cfg", {10'h0, cur_cfg}, {10'h0, d[6:4], d[2:0]});
        check("charge sense", charge_sense_code, chg);
        check("term sense", term_sense_dmv, term);
        read_exp(`CHG_CUR_ADDR, d | 8'h80);
    endtask : write_cfg

    task automatic test_reset_state;
        check("charger_reset idle", {15'h0, charger_reset}, 16'h0);
        check("cur_cfg reset", {10'h0, cur_cfg}, 16'h1);
        check("charge sense reset", charge_sense_code, 16'h176);
        check("term sense reset", term_sense_dmv, 16'h44);
        read_exp(`CHG_CUR_ADDR, 8'h89);
    endtask : test_reset_state

    task automatic test_fields;
        write_cfg(8'h7f, 16'h0, 16'h352, 16'h110);
        write_cfg(8'h80, 16'h2, 16'h176, 16'h22);
        write_cfg(8'h08, 16'h0, 16'h176, 16'h22);
        write_cfg(8'h15, 16'h0, 16'h1ba, 16'hcc);
    endtask : test_fields

    task automatic test_revision;
        read_exp(`REV_ID_ADDR, `REV_ID_VALUE);
        host_model_i.access(1'b1, `REV_ID_ADDR, 8'h07);
        read_exp(`REV_ID_ADDR, `REV_ID_VALUE);
        read_exp(8'h10, 8'hff);
    endtask : test_revision

    // Reset lands right after a write that sets both codes and asks for a charger reset
    task automatic test_mid_reset;
        host_model_i.access(1'b1, `CHG_CUR_ADDR, 8'hff);
        rst_n = 1'b0;
        repeat (2) begin
            @(posedge ref_clk);
            #1;
            check("charger_reset in reset", {15'h0, charger_reset}, 16'h0);
        end
        rst_n = 1'b1;
        @(posedge ref_clk);
        #1;
        test_reset_state();
    endtask : test_mid_reset

    task automatic test_timer;
        charging_active = 1'b1;
        @(posedge ref_clk);
        #1;
        check("timer run", {15'h0, safety_timer_run}, 16'h1);
        charging_active = 1'b0;
        #1;
        check("timer idle", {15'h0, safety_timer_run}, 16'h0);
    endtask : test_timer

    initial begin
        repeat (5) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        @(posedge ref_clk);
        #1;
        test_reset_state();
        test_fields();
        test_revision();
        test_mid_reset();
        test_timer();
        complete_run();
    end

    initial begin
        #20000;
        fail_count++;
        complete_run();
    end
endmodule : tb_charge_current_register_bank
